// [rtl/mpo_top.sv]
/*
  Pin output control of a hardware monitor with an APB register slave,
  sticky event status and one level interrupt.
  Assumes pins arrive asynchronously; the board resolves open-drain
  and open-source levels from the enables.
*/
// Notes on behaviour
// - Config bit 5 selects open-source NMI mode (1) or open-drain IRQ mode (0) for the host pin.
// - The host interrupt pin is driven only while config bit 2 is 1, else released.
// - After reset the host interrupt pin is disabled and in IRQ mode.
// - The management interrupt pin drives only while config bit 1 is set; off after reset.
// - A master reset pulse holds its pin low for at least 20 ms.
// - The master reset pin works only when mask register 2 bit 7 is set.
// - The dual-use pin is the fifth voltage-ID input by default, a tree output when programmed.
// - The four low voltage-ID inputs are readable in the voltage-ID and fan-divisor register.
// - An open-drain active-low power switch output is set by software.
// - The chained input reaches the management pin only when mask bit 6 and config bit 1 allow.
`timescale 1ns/1ns
module mpo_top #(
  parameter int RST_PULSE_CYC = mpo_pkg::RST_PULSE_CYC
) (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ,
  output logic HOST_INT_OUT,
  output logic HOST_INT_OE,
  output logic MGMT_INT_OE,
  output logic MASTER_RST_OE,
  output logic PWR_SW_OE,
  input wire logic VID4_IN,
  output logic VID4_OUT,
  output logic VID4_OE,
  input wire logic [3:0] VID_LOW_IN,
  input wire logic CHAIN_MGMT_INT_N,
  input wire logic BOARD_OVERTEMP_N,
  input wire logic [2:0] HOST_ADDR_LOW,
  input wire logic HOST_CS_N
);
  logic rst_s1_reg;
  logic rst_n;
  logic [mpo_pkg::SYNC_W-1:0] sy1_reg;
  logic [mpo_pkg::SYNC_W-1:0] sy_reg;
  logic [mpo_pkg::SYNC_W-1:0] sy_prev_reg;
  logic [7:0] config_reg, config_next;
  logic [7:0] mask2_reg, mask2_next;
  logic pwr_reg, pwr_next;
  logic tree_reg, tree_next;
  logic [1:0] fdiv_reg, fdiv_next;
  logic [mpo_pkg::EV_W-1:0] stat_reg, stat_next;
  logic [mpo_pkg::EV_W-1:0] ien_reg, ien_next;
  logic [31:0] prdata_reg, prdata_next;
  mpo_pkg::mpo_rst_e rst_st_reg, rst_st_next;
  logic [mpo_pkg::RST_CNT_W-1:0] cnt_reg, cnt_next;
  logic [mpo_pkg::SYNC_W-1:0] sy_in;
  logic setup, wr, hit;
  logic [31:0] rd_val;
  logic [mpo_pkg::EV_W-1:0] ev, clr;
  logic irq_lvl, mgmt_act;
  logic [mpo_pkg::RST_CNT_W-1:0] rst_hi_cnt_reg, rst_hi_cnt_next;
  localparam logic [mpo_pkg::RST_CNT_W-1:0] CNT_LAST =
    mpo_pkg::RST_CNT_W'(RST_PULSE_CYC - 1);

  // Reset release through two flops
  always_ff @(posedge MCLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end

  assign sy_in = {HOST_CS_N, HOST_ADDR_LOW, BOARD_OVERTEMP_N, CHAIN_MGMT_INT_N,
                  VID4_IN, VID_LOW_IN};

  // Pin synchronisers; idle level high for active-low pins
  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sy1_reg <= mpo_pkg::SYNC_RST;
      sy_reg <= mpo_pkg::SYNC_RST;
      sy_prev_reg <= mpo_pkg::SYNC_RST;
    end
    else
    begin
      sy1_reg <= sy_in;
      sy_reg <= sy1_reg;
      sy_prev_reg <= sy_reg;
    end
  end

  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE;

  always_comb
  begin
    hit = 1'b1;
    rd_val = 32'h0;
    if (PADDR == mpo_pkg::OFF_CONFIG)
      rd_val[7:0] = config_reg;
    else if (PADDR == mpo_pkg::OFF_MASK2)
      rd_val[7:0] = mask2_reg;
    else if (PADDR == mpo_pkg::OFF_PWR_SW)
      rd_val[mpo_pkg::PWR_SW_ON_BIT] = pwr_reg;
    else if (PADDR == mpo_pkg::OFF_VID_FAN)
    begin
      rd_val[mpo_pkg::VID_LOW_LSB +: 4] = sy_reg[mpo_pkg::SY_VID_LSB +: 4];
      rd_val[mpo_pkg::VID4_BIT] = sy_reg[mpo_pkg::SY_VID4] && !tree_reg;
      rd_val[mpo_pkg::FAN_DIV_LSB +: 2] = fdiv_reg;
    end
    else if (PADDR == mpo_pkg::OFF_TREE)
      rd_val[mpo_pkg::TREE_MODE_BIT] = tree_reg;
    else if (PADDR == mpo_pkg::OFF_INT_STATUS)
      rd_val[mpo_pkg::EV_W-1:0] = stat_reg;
    else if (PADDR == mpo_pkg::OFF_INT_CLEAR)
      rd_val = 32'h0;
    else if (PADDR == mpo_pkg::OFF_INT_ENABLE)
      rd_val[mpo_pkg::EV_W-1:0] = ien_reg;
    else if (PADDR == mpo_pkg::OFF_RST_CTRL)
      rd_val[mpo_pkg::RST_BUSY_BIT] = (rst_st_reg == mpo_pkg::MPO_RST_PULSE);
    else
      hit = 1'b0;
  end

  // Falling edges of the chained and overtemp inputs and pulse completion
  always_comb
  begin
    ev = '0;
    ev[mpo_pkg::EV_CHAIN] = sy_prev_reg[mpo_pkg::SY_CHAIN_N] && !sy_reg[mpo_pkg::SY_CHAIN_N];
    ev[mpo_pkg::EV_OVERTEMP] = sy_prev_reg[mpo_pkg::SY_OVERTEMP_N] &&
                               !sy_reg[mpo_pkg::SY_OVERTEMP_N];
    ev[mpo_pkg::EV_RST_DONE] = (rst_st_reg == mpo_pkg::MPO_RST_PULSE) && (cnt_reg == CNT_LAST);
    clr = (wr && PADDR == mpo_pkg::OFF_INT_CLEAR) ? PWDATA[mpo_pkg::EV_W-1:0] : '0;
  end

  always_comb
  begin
    config_next = config_reg;
    mask2_next = mask2_reg;
    pwr_next = pwr_reg;
    tree_next = tree_reg;
    fdiv_next = fdiv_reg;
    ien_next = ien_reg;
    stat_next = (stat_reg & ~clr) | ev;
    prdata_next = (setup && !PWRITE) ? rd_val : prdata_reg;
    rst_st_next = rst_st_reg;
    cnt_next = cnt_reg;
    if (wr)
    begin
      if (PADDR == mpo_pkg::OFF_CONFIG)
        config_next = PWDATA[7:0];
      else if (PADDR == mpo_pkg::OFF_MASK2)
        mask2_next = PWDATA[7:0];
      else if (PADDR == mpo_pkg::OFF_PWR_SW)
        pwr_next = PWDATA[mpo_pkg::PWR_SW_ON_BIT];
      else if (PADDR == mpo_pkg::OFF_VID_FAN)
        fdiv_next = PWDATA[mpo_pkg::FAN_DIV_LSB +: 2];
      else if (PADDR == mpo_pkg::OFF_TREE)
        tree_next = PWDATA[mpo_pkg::TREE_MODE_BIT];
      else if (PADDR == mpo_pkg::OFF_INT_ENABLE)
        ien_next = PWDATA[mpo_pkg::EV_W-1:0];
    end
    case (rst_st_reg)
      mpo_pkg::MPO_RST_IDLE:
      begin
        cnt_next = '0;
        if (wr && PADDR == mpo_pkg::OFF_RST_CTRL && PWDATA[mpo_pkg::RST_START_BIT] &&
            mask2_reg[mpo_pkg::MASK2_RST_EN_BIT])
          rst_st_next = mpo_pkg::MPO_RST_PULSE;
      end
      mpo_pkg::MPO_RST_PULSE:
      begin
        cnt_next = cnt_reg + 1'b1;
        if (cnt_reg == CNT_LAST)
        begin
          rst_st_next = mpo_pkg::MPO_RST_IDLE;
          cnt_next = '0;
        end
      end
      default:
        rst_st_next = mpo_pkg::MPO_RST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
    begin
      config_reg <= mpo_pkg::CONFIG_RST;
      mask2_reg <= mpo_pkg::MASK2_RST;
      pwr_reg <= 1'b0;
      tree_reg <= 1'b0;
      fdiv_reg <= mpo_pkg::FAN_DIV_RST;
      ien_reg <= '0;
      stat_reg <= '0;
      prdata_reg <= 32'h0;
      rst_st_reg <= mpo_pkg::MPO_RST_IDLE;
      cnt_reg <= '0;
    end
    else
    begin
      config_reg <= config_next;
      mask2_reg <= mask2_next;
      pwr_reg <= pwr_next;
      tree_reg <= tree_next;
      fdiv_reg <= fdiv_next;
      ien_reg <= ien_next;
      stat_reg <= stat_next;
      prdata_reg <= prdata_next;
      rst_st_reg <= rst_st_next;
      cnt_reg <= cnt_next;
    end
  end

  assign irq_lvl = |(stat_reg & ien_reg);
  assign mgmt_act = !sy_reg[mpo_pkg::SY_CHAIN_N] && mask2_reg[mpo_pkg::MASK2_CHAIN_BIT];

  assign PRDATA = prdata_reg;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !hit;
  assign IRQ = irq_lvl;
  assign HOST_INT_OUT = config_reg[mpo_pkg::CFG_NMI_MODE_BIT];
  assign HOST_INT_OE = irq_lvl && config_reg[mpo_pkg::CFG_HOST_EN_BIT];
  assign MGMT_INT_OE = mgmt_act && config_reg[mpo_pkg::CFG_MGMT_EN_BIT];
  assign MASTER_RST_OE = (rst_st_reg == mpo_pkg::MPO_RST_PULSE);
  assign PWR_SW_OE = pwr_reg;
  // Tree output is the NAND of the other synchronised inputs
  assign VID4_OUT = ~&{sy_reg[mpo_pkg::SY_CS_N:mpo_pkg::SY_CHAIN_N],
                       sy_reg[mpo_pkg::SY_VID_LSB +: 4]};
  assign VID4_OE = tree_reg;

  // Cycles the reset pin has been held, for the width check
  always_comb
  begin
    rst_hi_cnt_next = '0;
    if (MASTER_RST_OE)
      rst_hi_cnt_next = rst_hi_cnt_reg + 1'b1;
  end

  always_ff @(posedge MCLK or negedge rst_n)
  begin
    if (!rst_n)
      rst_hi_cnt_reg <= '0;
    else
      rst_hi_cnt_reg <= rst_hi_cnt_next;
  end

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!rst_n);

  sequence pulse_start_s;
    rst_st_reg == mpo_pkg::MPO_RST_IDLE && wr && PADDR == mpo_pkg::OFF_RST_CTRL &&
    PWDATA[mpo_pkg::RST_START_BIT];
  endsequence

  host_mode_a: assert property (HOST_INT_OE |->
    HOST_INT_OUT == config_reg[mpo_pkg::CFG_NMI_MODE_BIT])
    else $error("host pin level does not follow mode bit");
  host_enable_a: assert property (!config_reg[mpo_pkg::CFG_HOST_EN_BIT] |->
    !HOST_INT_OE)
    else $error("host pin driven while disabled");
  host_reset_a: assert property ($rose(rst_n) |-> !HOST_INT_OE &&
    !config_reg[mpo_pkg::CFG_NMI_MODE_BIT])
    else $error("host pin not disabled irq mode after reset");
  mgmt_enable_a: assert property (MGMT_INT_OE |-> config_reg[mpo_pkg::CFG_MGMT_EN_BIT] &&
    mask2_reg[mpo_pkg::MASK2_CHAIN_BIT])
    else $error("management pin driven without enables");
  rst_width_a: assert property ($rose(MASTER_RST_OE) |-> MASTER_RST_OE [*8])
    else $error("master reset pulse too short");
  rst_len_a: assert property ($fell(MASTER_RST_OE) |-> rst_hi_cnt_reg > CNT_LAST)
    else $error("master reset pulse shorter than its count");
  rst_gate_a: assert property (pulse_start_s ##0
    !mask2_reg[mpo_pkg::MASK2_RST_EN_BIT] |=> !MASTER_RST_OE)
    else $error("master reset started while not enabled");
  rst_start_a: assert property (pulse_start_s ##0
    mask2_reg[mpo_pkg::MASK2_RST_EN_BIT] |=> MASTER_RST_OE)
    else $error("master reset did not start");
  tree_mode_a: assert property ($rose(tree_reg) |-> VID4_OE)
    else $error("tree pin not driven in tree mode");
  chain_pass_a: assert property (config_reg[mpo_pkg::CFG_MGMT_EN_BIT] &&
    mask2_reg[mpo_pkg::MASK2_CHAIN_BIT] && !sy_reg[mpo_pkg::SY_CHAIN_N] |-> MGMT_INT_OE)
    else $error("chained interrupt not passed");
  pwr_drive_a: assert property (wr && PADDR == mpo_pkg::OFF_PWR_SW
    |=> PWR_SW_OE == $past(PWDATA[mpo_pkg::PWR_SW_ON_BIT]))
    else $error("power switch did not follow write");
  vid_read_a: assert property (setup && !PWRITE && PADDR == mpo_pkg::OFF_VID_FAN
    |=> PRDATA[mpo_pkg::VID_LOW_LSB +: 4] == $past(sy_reg[mpo_pkg::SY_VID_LSB +: 4]))
    else $error("voltage id read mismatch");
  event_set_a: assert property (ev != '0
    |=> (stat_reg & $past(ev)) == $past(ev))
    else $error("event did not set its status bit");
  event_clear_a: assert property (wr && PADDR == mpo_pkg::OFF_INT_CLEAR && ev == '0
    |=> (stat_reg & $past(PWDATA[mpo_pkg::EV_W-1:0])) == '0)
    else $error("status bit not cleared by write");
endmodule // mpo_top

// [rtl/mpo_pkg.sv]
/*
  Constants for the monitor pin output control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 50 MHz clock and an APB master with byte addresses.
*/
package mpo_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_MASK2 = 8'h04;
  localparam logic [7:0] OFF_PWR_SW = 8'h08;
  localparam logic [7:0] OFF_VID_FAN = 8'h0c;
  localparam logic [7:0] OFF_TREE = 8'h10;
  localparam logic [7:0] OFF_INT_STATUS = 8'h14;
  localparam logic [7:0] OFF_INT_CLEAR = 8'h18;
  localparam logic [7:0] OFF_INT_ENABLE = 8'h1c;
  localparam logic [7:0] OFF_RST_CTRL = 8'h20;

  localparam int CFG_MGMT_EN_BIT = 1;
  localparam int CFG_HOST_EN_BIT = 2;
  localparam int CFG_NMI_MODE_BIT = 5;
  localparam int MASK2_CHAIN_BIT = 6;
  localparam int MASK2_RST_EN_BIT = 7;
  localparam int PWR_SW_ON_BIT = 0;
  localparam int TREE_MODE_BIT = 0;
  localparam int RST_START_BIT = 0;
  localparam int RST_BUSY_BIT = 1;
  localparam int VID_LOW_LSB = 0;
  localparam int VID4_BIT = 4;
  localparam int FAN_DIV_LSB = 6;

  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [7:0] MASK2_RST = 8'h00;
  localparam logic [1:0] FAN_DIV_RST = 2'h1;

  localparam int EV_W = 3;
  localparam int EV_CHAIN = 0;
  localparam int EV_OVERTEMP = 1;
  localparam int EV_RST_DONE = 2;

  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_PULSE_MS = 20;
  localparam int RST_PULSE_CYC = (RST_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_CNT_W = 20;

  localparam int SYNC_W = 11;
  localparam int SY_VID_LSB = 0;
  localparam int SY_VID4 = 4;
  localparam int SY_CHAIN_N = 5;
  localparam int SY_OVERTEMP_N = 6;
  localparam int SY_ADDR_LSB = 7;
  localparam int SY_CS_N = 10;
  // Idle levels of the synchronised pins; active-low pins rest high
  localparam logic [SYNC_W-1:0] SYNC_RST = 11'h460;

  typedef enum logic [0:0] {
    MPO_RST_IDLE = 1'b0,
    MPO_RST_PULSE = 1'b1
  } mpo_rst_e;
endpackage

// [tb/mpo_host_model.sv]
/*
  Host side of the parallel port: an outside decoder and the low
  address lines. Assumes the bench supplies the 16-bit I/O address.
*/
`timescale 1ns/1ns
module mpo_host_model #(
  parameter logic [15:0] BASE = 16'h0340 // Arbitrary I/O base
) (
  input wire logic [15:0] io_addr,
  output logic [2:0] addr_low,
  output logic cs_n
);
  assign addr_low = io_addr[2:0];
  assign cs_n = io_addr[15:3] != BASE[15:3];
endmodule // mpo_host_model

// [tb/monitor_pin_output_control_bench.sv]
/*
  Self-checking bench for mpo_top over APB with a host decoder model.
  Assumes a short reset pulse parameter of 16 cycles.
*/
`timescale 1ns/1ns
module monitor_pin_output_control_bench;
  localparam int PULSE_CYC = 16;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, irq, host_out, host_oe, mgmt_oe, mrst_oe, pwr_oe, vid4_out, vid4_oe;
  logic vid4_drv = 1'b1;
  logic [3:0] vid_low = 4'h0;
  logic chain_n = 1'b1;
  logic ot_n = 1'b1;
  logic [15:0] io_addr = 16'h0000;
  logic [2:0] addr_low;
  logic cs_n;
  logic vid4_pin;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int n_tests = 0;
  // Dual-use pin level from both drivers
  assign vid4_pin = vid4_oe ? vid4_out : vid4_drv;
  mpo_host_model u_mpo_host_model (.io_addr(io_addr), .addr_low(addr_low), .cs_n(cs_n));
  mpo_top #(.RST_PULSE_CYC(PULSE_CYC)) u_mpo_top (.MCLK(mclk), .RESET_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .HOST_INT_OUT(host_out),
    .HOST_INT_OE(host_oe), .MGMT_INT_OE(mgmt_oe), .MASTER_RST_OE(mrst_oe),
    .PWR_SW_OE(pwr_oe), .VID4_IN(vid4_pin), .VID4_OUT(vid4_out), .VID4_OE(vid4_oe),
    .VID_LOW_IN(vid_low), .CHAIN_MGMT_INT_N(chain_n), .BOARD_OVERTEMP_N(ot_n),
    .HOST_ADDR_LOW(addr_low), .HOST_CS_N(cs_n));
  initial forever #10 mclk = ~mclk;
  task idle(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    idle(2);
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask
  task t_reset;
    check(32'(pready), 32'h1);
    check(32'({host_oe, host_out, mgmt_oe, mrst_oe, pwr_oe}), 32'h0);
    check(32'(vid4_oe), 32'h0);
    rdc(mpo_pkg::OFF_CONFIG, 32'h0);
    rdc(mpo_pkg::OFF_VID_FAN, 32'h50);
    apb(1'b0, 8'h3c, 32'h0);
    check(32'({err, rd[0]}), 32'h2);
  endtask
  task t_host;
    wr(mpo_pkg::OFF_INT_ENABLE, 32'h2);
    ot_n <= 1'b0;
    idle(5);
    check(32'({irq, host_oe}), 32'h2);
    wr(mpo_pkg::OFF_CONFIG, 32'h24);
    check(32'({host_oe, host_out}), 32'h3);
    wr(mpo_pkg::OFF_CONFIG, 32'h04);
    check(32'({host_oe, host_out}), 32'h2);
    ot_n <= 1'b1;
    wr(mpo_pkg::OFF_INT_CLEAR, 32'h2);
    check(32'({irq, host_oe}), 32'h0);
    rdc(mpo_pkg::OFF_INT_STATUS, 32'h0);
    wr(mpo_pkg::OFF_CONFIG, 32'h00);
  endtask
  task t_mgmt;
    wr(mpo_pkg::OFF_CONFIG, 32'h2);
    chain_n <= 1'b0;
    idle(5);
    check(32'(mgmt_oe), 32'h0);
    wr(mpo_pkg::OFF_MASK2, 32'h40);
    check(32'(mgmt_oe), 32'h1);
    wr(mpo_pkg::OFF_CONFIG, 32'h0);
    check(32'(mgmt_oe), 32'h0);
    chain_n <= 1'b1;
    rdc(mpo_pkg::OFF_INT_STATUS, 32'h1);
    wr(mpo_pkg::OFF_INT_CLEAR, 32'h7);
  endtask
  task t_rst;
    int n;
    wr(mpo_pkg::OFF_RST_CTRL, 32'h1);
    check(32'(mrst_oe), 32'h0);
    wr(mpo_pkg::OFF_MASK2, 32'h80);
    apb(1'b1, mpo_pkg::OFF_RST_CTRL, 32'h1);
    n = 0;
    repeat (40)
    begin
      @(posedge mclk);
      if (mrst_oe === 1'b1) n++;
    end
    check(32'(n), 32'(PULSE_CYC));
    rdc(mpo_pkg::OFF_INT_STATUS, 32'h4);
  endtask
  task t_pwr;
    wr(mpo_pkg::OFF_PWR_SW, 32'h1);
    check(32'(pwr_oe), 32'h1);
    wr(mpo_pkg::OFF_PWR_SW, 32'h0);
    check(32'(pwr_oe), 32'h0);
  endtask
  task t_vid;
    vid_low <= 4'ha;
    idle(5);
    rdc(mpo_pkg::OFF_VID_FAN, 32'h5a);
    wr(mpo_pkg::OFF_TREE, 32'h1);
    io_addr <= 16'h0347;
    idle(5);
    check(32'({vid4_oe, vid4_out}), 32'h3);
    io_addr <= 16'h0007;
    vid_low <= 4'hf;
    idle(5);
    check(32'({vid4_oe, vid4_out}), 32'h2);
    rdc(mpo_pkg::OFF_VID_FAN, 32'h4f);
    wr(mpo_pkg::OFF_VID_FAN, 32'h80);
    rdc(mpo_pkg::OFF_VID_FAN, 32'h8f);
  endtask
  task t_rerun;
    wr(mpo_pkg::OFF_CONFIG, 32'h26);
    wr(mpo_pkg::OFF_MASK2, 32'hc0);
    wr(mpo_pkg::OFF_PWR_SW, 32'h1);
    rst_n <= 1'b0;
    idle(2);
    rst_n <= 1'b1;
    idle(3);
    check(32'({host_oe, host_out, mgmt_oe, mrst_oe, pwr_oe, vid4_oe}), 32'h0);
    rdc(mpo_pkg::OFF_CONFIG, 32'h0);
    rdc(mpo_pkg::OFF_MASK2, 32'h0);
    rdc(mpo_pkg::OFF_VID_FAN, 32'h5f);
  endtask
  task summarize;
    $display("checks=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    idle(5);
    rst_n <= 1'b1;
    idle(3);
    t_reset();
    t_host();
    t_mgmt();
    t_rst();
    t_pwr();
    t_vid();
    t_rerun();
    summarize();
  end
  initial
  begin
    #400000;
    fail_count++;
    summarize();
  end
endmodule // monitor_pin_output_control_bench
